// >>> mfpr_pkg.sv
// Constants for the multifunction pin routing block
// Contract
// R1 - Output register bits 4..0 drive general outputs 0..4; readable and writable. Only bits 1 and 4 reach a terminal (terminals 1 and 5).
// R2 - Output register bits 7..5 read zero; writes there are ignored.
// R3 - Output levels clear only on global reset, not other resets.
// R4 - Routing register holds seven 4-bit selectors, terminal 0 lowest nibble.
// R5 - Routing resets to 0x00001000; default may come from serial EEPROM.
// R6 - Routing bits 31..28 read zero and are not writable.
// R7 - Terminal 0 codes: input0, PWM, IRQ9, IRQ10, LED, event, IRQ15.
// R8 - Terminal 1 codes: input1, output1, INTB, IRQ3/5/9/10/15, LEDs, PWM, event.
// R9 - Terminal 2 codes: PWM, IRQ10, ring out, test_multiplexer, event, IRQ7.
// R10 - Terminal 3: 0000 reserved; upper codes map IRQ8..IRQ15; code 1011 (IRQ11) left undriven.
// R11 - Terminal 4 codes: input3, PWM, IRQ9, INTD, ring, socket LED, event, IRQ15.
// R12 - Terminal 5 codes: input4, output4, IRQ3/9/15, PWM, LEDs, event.
// R13 - Terminal 6: 0000 reserved; upper codes map IRQ8..IRQ15; code 1011 (IRQ11) left undriven.
// R14 - Selectors return to defaults only on global reset.
// R15 - Software should program routing once at power-on.
// R16 - Event output asserts when any status bit and its enable are set.
// R17 - Reserved selector code leaves terminal undriven, treated as unused input.
`default_nettype none
package mfpr_pkg;
   localparam logic [7:0] MFPR_OFS_GPO = 8'h8B;
   localparam logic [7:0] MFPR_OFS_ROUTE = 8'h8C;
   localparam int MFPR_GPO_W = 5;
   localparam int MFPR_NPIN = 7;
   localparam int MFPR_SEL_W = 4;
   localparam int MFPR_SEL_USED = 28;
   localparam logic [4:0] MFPR_GPO_RST = 5'h00;
   localparam logic [27:0] MFPR_ROUTE_RST = 28'h0001000;
   // Selector codes
   localparam logic [3:0] SEL_C0 = 4'h0;
   localparam logic [3:0] SEL_C1 = 4'h1;
   localparam logic [3:0] SEL_C2 = 4'h2;
   localparam logic [3:0] SEL_C3 = 4'h3;
   localparam logic [3:0] SEL_C4 = 4'h4;
   localparam logic [3:0] SEL_C5 = 4'h5;
   localparam logic [3:0] SEL_C8 = 4'h8;
   localparam logic [3:0] SEL_C9 = 4'h9;
   localparam logic [3:0] SEL_CA = 4'hA;
   localparam logic [3:0] SEL_CC = 4'hC;
   localparam logic [3:0] SEL_CD = 4'hD;
   localparam logic [3:0] SEL_CE = 4'hE;
   localparam logic [3:0] SEL_CF = 4'hF;
   // Interrupt line indices in the 16-bit IRQ vector
   localparam int IRQ3 = 3;
   localparam int IRQ5 = 5;
   localparam int IRQ7 = 7;
   localparam int IRQ8 = 8;
   localparam int IRQ9 = 9;
   localparam int IRQ10 = 10;
   localparam int IRQ12 = 12;
   localparam int IRQ13 = 13;
   localparam int IRQ14 = 14;
   localparam int IRQ15 = 15;
endpackage
`default_nettype wire

// >>> mfpr_top.sv
// Multifunction terminal routing with general output register
`default_nettype none
module mfpr_top (
   input wire logic I_CLK_SYS,
   input wire logic I_SRST,
   input wire logic i_global_reset_n,
   input wire logic i_eeprom_load,
   input wire logic [27:0] i_eeprom_route,
   input wire logic [7:0] i_cfg_addr,
   input wire logic i_cfg_wr,
   input wire logic [3:0] i_cfg_be,
   input wire logic [31:0] i_cfg_wdata,
   output logic [31:0] o_cfg_rdata,
   input wire logic [7:0] i_event_status,
   input wire logic [7:0] i_event_enable,
   input wire logic [15:0] i_irq,
   input wire logic i_intb,
   input wire logic i_intd,
   input wire logic i_card_audio_pwm,
   input wire logic i_activity_led_a,
   input wire logic i_host_led,
   input wire logic i_socket_led,
   input wire logic i_ring_indicate_out,
   input wire logic i_test_multiplexer,
   input wire logic [6:0] i_pin,
   output logic [6:0] o_pin,
   output logic [6:0] o_pin_oe,
   output logic [4:0] o_gen_input
);
   import mfpr_pkg::*;

   logic global_reset_q;
   logic [4:0] gpo_q;
   logic [4:0] gpo_d;
   logic [27:0] route_q;
   logic [27:0] route_d;
   logic [6:0] pin_d;
   logic [6:0] oe_d;
   logic [4:0] gin_d;
   logic [31:0] rdata_d;
   logic event_out;
   logic [3:0] sel [MFPR_NPIN];

   // Registered global reset, active high internally
   always_ff @(posedge I_CLK_SYS) begin
      global_reset_q <= ~i_global_reset_n;
   end

   // Register decode; byte address selects the register, lane 0 base
   wire hit_gpo = (i_cfg_addr == MFPR_OFS_GPO);
   wire hit_route = (i_cfg_addr == MFPR_OFS_ROUTE);
   wire wr_gpo = i_cfg_wr & hit_gpo & i_cfg_be[0];
   wire wr_route = i_cfg_wr & hit_route;

   // Next output levels; only low five bits stored
   assign gpo_d = wr_gpo ? i_cfg_wdata[4:0] : gpo_q; // R1 R2

   // Routing register byte-lane write, top nibble never stored
   always_comb begin
      route_d = route_q;
      if (wr_route) begin
         if (i_cfg_be[0]) route_d[7:0] = i_cfg_wdata[7:0];
         if (i_cfg_be[1]) route_d[15:8] = i_cfg_wdata[15:8];
         if (i_cfg_be[2]) route_d[23:16] = i_cfg_wdata[23:16];
         if (i_cfg_be[3]) route_d[27:24] = i_cfg_wdata[27:24]; // R6
      end
      if (i_eeprom_load) begin
         route_d = i_eeprom_route; // R5
      end
   end

   // Registers cleared by global reset only; I_SRST leaves them alone
   always_ff @(posedge I_CLK_SYS) begin
      if (global_reset_q) begin
         gpo_q <= MFPR_GPO_RST; // R3
         route_q <= MFPR_ROUTE_RST; // R5 R14
      end else begin
         gpo_q <= gpo_d;
         route_q <= route_d;
      end
   end

   // Selector field split
   genvar g;
   generate
      for (g = 0; g < MFPR_NPIN; g++) begin : g_sel
         assign sel[g] = route_q[g*MFPR_SEL_W +: MFPR_SEL_W]; // R4
      end
   endgenerate

   // Event output, active low on the pin
   assign event_out = |(i_event_status & i_event_enable); // R16

   // Per-terminal mux: returns {drive, level}; reserved codes not driven
   function automatic logic [1:0] pin_mux(input int pin, input logic [3:0] s);
      logic [1:0] r;
      r = 2'b00; // R17
      unique case (pin)
         0: begin // R7
            if (s == SEL_C8) r = {1'b1, i_card_audio_pwm};
            else if (s == SEL_C9) r = {1'b1, i_irq[IRQ9]};
            else if (s == SEL_CA) r = {1'b1, i_irq[IRQ10]};
            else if (s == SEL_CC) r = {1'b1, i_activity_led_a};
            else if (s == SEL_CE) r = {1'b1, ~event_out};
            else if (s == SEL_CF) r = {1'b1, i_irq[IRQ15]};
         end
         1: begin // R8
            if (s == SEL_C1) r = {1'b1, gpo_q[1]};
            else if (s == SEL_C2) r = {1'b1, i_intb};
            else if (s == SEL_C3) r = {1'b1, i_irq[IRQ3]};
            else if (s == SEL_C4) r = {1'b1, i_host_led};
            else if (s == SEL_C5) r = {1'b1, i_irq[IRQ5]};
            else if (s == SEL_C8) r = {1'b1, i_card_audio_pwm};
            else if (s == SEL_C9) r = {1'b1, i_irq[IRQ9]};
            else if (s == SEL_CA) r = {1'b1, i_irq[IRQ10]};
            else if (s == SEL_CC) r = {1'b1, i_activity_led_a};
            else if (s == SEL_CE) r = {1'b1, ~event_out};
            else if (s == SEL_CF) r = {1'b1, i_irq[IRQ15]};
         end
         2: begin // R9
            if (s == SEL_C8) r = {1'b1, i_card_audio_pwm};
            else if (s == SEL_CA) r = {1'b1, i_irq[IRQ10]};
            else if (s == SEL_CC) r = {1'b1, i_ring_indicate_out};
            else if (s == SEL_CD) r = {1'b1, i_test_multiplexer};
            else if (s == SEL_CE) r = {1'b1, ~event_out};
            else if (s == SEL_CF) r = {1'b1, i_irq[IRQ7]};
         end
         4: begin // R11
            if (s == SEL_C8) r = {1'b1, i_card_audio_pwm};
            else if (s == SEL_C9) r = {1'b1, i_irq[IRQ9]};
            else if (s == SEL_CA) r = {1'b1, i_intd};
            else if (s == SEL_CC) r = {1'b1, i_ring_indicate_out};
            else if (s == SEL_CD) r = {1'b1, i_socket_led};
            else if (s == SEL_CE) r = {1'b1, ~event_out};
            else if (s == SEL_CF) r = {1'b1, i_irq[IRQ15]};
         end
         5: begin // R12
            if (s == SEL_C1) r = {1'b1, gpo_q[4]};
            else if (s == SEL_C3) r = {1'b1, i_irq[IRQ3]};
            else if (s == SEL_C8) r = {1'b1, i_card_audio_pwm};
            else if (s == SEL_C9) r = {1'b1, i_irq[IRQ9]};
            else if (s == SEL_CC) r = {1'b1, i_activity_led_a};
            else if (s == SEL_CD) r = {1'b1, i_socket_led};
            else if (s == SEL_CE) r = {1'b1, ~event_out};
            else if (s == SEL_CF) r = {1'b1, i_irq[IRQ15]};
         end
         default: begin // R10 R13
            if (s == SEL_C8) r = {1'b1, i_irq[IRQ8]};
            else if (s == SEL_C9) r = {1'b1, i_irq[IRQ9]};
            else if (s == SEL_CA) r = {1'b1, i_irq[IRQ10]};
            else if (s == SEL_CC) r = {1'b1, i_irq[IRQ12]};
            else if (s == SEL_CD) r = {1'b1, i_irq[IRQ13]};
            else if (s == SEL_CE) r = {1'b1, i_irq[IRQ14]};
            else if (s == SEL_CF) r = {1'b1, i_irq[IRQ15]};
         end
      endcase
      return r;
   endfunction

   // Terminal drive and enable; a process, so source changes re-run the mux
   always_comb begin
      for (int k = 0; k < MFPR_NPIN; k++) begin
         {oe_d[k], pin_d[k]} = pin_mux(k, sel[k]);
      end
   end

   // General inputs sampled from terminals set as inputs, else zero
   assign gin_d[0] = (sel[0] == SEL_C0) & i_pin[0];
   assign gin_d[1] = (sel[1] == SEL_C0) & i_pin[1];
   assign gin_d[2] = 1'b0;
   assign gin_d[3] = (sel[4] == SEL_C0) & i_pin[4];
   assign gin_d[4] = (sel[5] == SEL_C0) & i_pin[5];

   // Read data; upper bits zero
   assign rdata_d = hit_gpo ? {27'h0000000, gpo_q} : // R2
                    hit_route ? {4'h0, route_q} : 32'h00000000; // R6

   // Output flops
   always_ff @(posedge I_CLK_SYS) begin
      if (I_SRST | global_reset_q) begin
         o_pin <= 7'h00;
         o_pin_oe <= 7'h00;
         o_gen_input <= 5'h00;
         o_cfg_rdata <= 32'h00000000;
      end else begin
         o_pin <= pin_d;
         o_pin_oe <= oe_d;
         o_gen_input <= gin_d;
         o_cfg_rdata <= rdata_d;
      end
   end

   AST_GPO_WRITE: assert property (@(posedge I_CLK_SYS) disable iff (global_reset_q)
      wr_gpo |=> gpo_q == $past(i_cfg_wdata[4:0])) else $error("gpo write lost"); // R1
   AST_GPO_RD: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST | global_reset_q)
      hit_gpo |=> o_cfg_rdata[31:5] == 27'h0000000) else $error("gpo upper nonzero"); // R2
   AST_GPO_KEEP: assert property (@(posedge I_CLK_SYS)
      (I_SRST & !global_reset_q & !wr_gpo) |=> $stable(gpo_q)) else $error("gpo lost"); // R3
   AST_ROUTE_RST: assert property (@(posedge I_CLK_SYS)
      global_reset_q |=> route_q == MFPR_ROUTE_RST) else $error("route reset"); // R5
   AST_ROUTE_KEEP: assert property (@(posedge I_CLK_SYS)
      (I_SRST & !global_reset_q & !wr_route & !i_eeprom_load) |=> $stable(route_q))
      else $error("route lost"); // R14
   AST_ROUTE_TOP: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST | global_reset_q)
      hit_route |=> o_cfg_rdata[31:28] == 4'h0) else $error("route top"); // R6
   AST_EVENT: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST | global_reset_q)
      (sel[0] == SEL_CE) |=> o_pin_oe[0] && o_pin[0] == !$past(event_out))
      else $error("event pin"); // R16
   AST_RSVD: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST | global_reset_q)
      (sel[3] == SEL_C0) |=> !o_pin_oe[3]) else $error("reserved driven"); // R17
   AST_ROUTE_WR: assert property (@(posedge I_CLK_SYS) disable iff (global_reset_q)
      (wr_route & (i_cfg_be == 4'hF) & !i_eeprom_load) |=> route_q == $past(i_cfg_wdata[27:0]))
      else $error("route write lost"); // R4
   AST_IRQ12_T3: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST | global_reset_q)
      (sel[3] == SEL_CC) |=> o_pin_oe[3] && o_pin[3] == $past(i_irq[IRQ12]))
      else $error("terminal 3 irq"); // R10
endmodule
`default_nettype wire

// >>> mfpr_top_tb.sv
// Self-checking bench for the multifunction terminal routing block
`default_nettype none
module mfpr_top_tb;
   import mfpr_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   // Source pattern bits: 0-15 irq, 16 intb, 17 intd, 18 pwm, 19 led, 20 host led,
   // 21 socket led, 22 ring, 23 test_multiplexer, 24 event pin level, 25 out1, 26 out4
   localparam logic [26:0] PAT = 27'h5A3C96B;
   // Per terminal, byte per code: FF undriven, FE unchecked, else source bit
   localparam logic [127:0] TBL [7] = '{128'h0F18FF13FE0A0912FEFEFEFEFEFEFEFF,
      128'h0F18FF13FE0A0912FFFF0514031019FF, 128'h07181716FE0AFF12FEFEFEFEFEFEFEFE,
      128'h0F0E0D0CFE0A0908FEFEFEFEFEFEFEFF, 128'h0F181516FE110912FEFEFEFEFEFEFEFF,
      128'h0F181513FEFF0912FEFEFEFE03FF1AFF, 128'h0F0E0D0CFE0A0908FEFEFEFEFEFEFEFF};
   logic clk = 1'b0, srst = 1'b1, global_reset_n_n = 1'b0, ee_ld = 1'b0, wr = 1'b0;
   logic [27:0] ee_route = 28'h0000000;
   logic [7:0] addr = 8'h00, ev_en = 8'h00;
   logic [3:0] be = 4'h0;
   logic [31:0] wdata = 32'h00000000, rdata;
   logic [15:0] irq = 16'h0000;
   logic [6:0] pin_in = 7'h00, pin_out, pin_oe;
   logic [4:0] gen_in;
   logic [26:0] srcv = 27'h0;
   int bad_count = 0, n_compared = 0;
   mfpr_top dut_u (.I_CLK_SYS(clk), .I_SRST(srst), .i_global_reset_n(global_reset_n_n),
      .i_eeprom_load(ee_ld), .i_eeprom_route(ee_route), .i_cfg_addr(addr), .i_cfg_wr(wr),
      .i_cfg_be(be), .i_cfg_wdata(wdata), .o_cfg_rdata(rdata), .i_event_status(8'hFF),
      .i_event_enable(ev_en), .i_irq(irq), .i_intb(srcv[16]), .i_intd(srcv[17]),
      .i_card_audio_pwm(srcv[18]), .i_activity_led_a(srcv[19]), .i_host_led(srcv[20]),
      .i_socket_led(srcv[21]), .i_ring_indicate_out(srcv[22]), .i_test_multiplexer(srcv[23]),
      .i_pin(pin_in), .o_pin(pin_out), .o_pin_oe(pin_oe), .o_gen_input(gen_in));
   // Clock, 40 ns period
   initial begin
      forever #20 clk = ~clk;
   end
   task automatic report_and_stop();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
      @(negedge clk);
      addr = a;
      be = b;
      wdata = d;
      wr = 1'b1;
      @(negedge clk);
      wr = 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      @(negedge clk);
      addr = a;
      @(posedge clk);
      @(negedge clk);
      chk(rdata, exp);
   endtask
   // Drive every routed source from the pattern or its inverse
   task automatic set_src(input bit p);
      srcv = p ? ~PAT : PAT;
      wr_reg(MFPR_OFS_GPO, 4'h1, {27'h0, srcv[26], 2'b00, srcv[25], 1'b0});
      irq = srcv[15:0];
      ev_en = {7'h00, ~srcv[24]};
      pin_in = srcv[6:0];
      @(posedge clk);
      @(posedge clk);
      @(negedge clk);
   endtask
   task automatic glob_reset();
      @(negedge clk);
      global_reset_n_n = 1'b0;
      repeat (3) @(negedge clk);
      global_reset_n_n = 1'b1;
   endtask
   // Watchdog
   initial begin
      repeat (100000) @(posedge clk);
      bad_count++;
      report_and_stop();
   end
   initial begin
      logic [7:0] idx;
      repeat (20) @(negedge clk);
      srst = 1'b0;
      global_reset_n_n = 1'b1;
      rd_chk(MFPR_OFS_ROUTE, 32'h00001000);
      rd_chk(MFPR_OFS_GPO, 32'h00000000);
      wr_reg(MFPR_OFS_GPO, 4'hF, 32'hFFFFFFFF);
      rd_chk(MFPR_OFS_GPO, 32'h0000001F);
      wr_reg(MFPR_OFS_ROUTE, 4'h2, 32'hFFFFFFFF);
      rd_chk(MFPR_OFS_ROUTE, 32'h0000FF00);
      wr_reg(MFPR_OFS_ROUTE, 4'hF, 32'hFFFFFFFF);
      rd_chk(MFPR_OFS_ROUTE, 32'h0FFFFFFF);
      rd_chk(8'h90, 32'h00000000);
      @(negedge clk);
      srst = 1'b1;
      @(negedge clk);
      srst = 1'b0;
      rd_chk(MFPR_OFS_GPO, 32'h0000001F);
      rd_chk(MFPR_OFS_ROUTE, 32'h0FFFFFFF);
      glob_reset();
      rd_chk(MFPR_OFS_GPO, 32'h00000000);
      rd_chk(MFPR_OFS_ROUTE, 32'h00001000);
      @(negedge clk);
      ee_route = 28'h9ABCDEF;
      ee_ld = 1'b1;
      @(negedge clk);
      ee_ld = 1'b0;
      rd_chk(MFPR_OFS_ROUTE, 32'h09ABCDEF);
      // Every code on every terminal, both source polarities
      for (int c = 0; c < 16; c++) begin
         wr_reg(MFPR_OFS_ROUTE, 4'hF, {4'h0, {7{c[3:0]}}});
         for (int p = 0; p < 2; p++) begin
            set_src(p[0]);
            for (int t = 0; t < 7; t++) begin
               idx = TBL[t][c*8 +: 8];
               if (idx == 8'hFF) begin
                  chk({31'h0, pin_oe[t]}, 32'h0);
               end else if (idx != 8'hFE) begin
                  chk({30'h0, pin_oe[t], pin_out[t]}, {30'h0, 1'b1, srcv[idx]});
               end
            end
            chk({27'h0, gen_in}, (c == 0) ? {27'h0, pin_in[5:4], 1'b0, pin_in[1:0]} : 32'h0);
         end
      end
      report_and_stop();
   end
endmodule
`default_nettype wire
